// [hdl/ntid_regs.v]
// target identifier, detection level and target protocol registers
// assumes an axi4-lite master on clk; rf comparators and protocol
// decoder are synchronous inputs from the analog and framing logic
// Behaviour
// - store identifier bytes for anticollision answers
// - size code 00=4, 01=7, 10=10 bytes
// - sdd enable runs internal anticollision engine
// - zero wake level disables wake detection
// - detection level reset only by supply por
// - extended range bit widens rf measurement
// - status shows first command rate, protocol
// - low five bits clear after read burst
// - bits 7,6 live comparator outputs, unlatched
// - bit 4 one for type f coding
// - bit 3 for sens_req or all_req
// - bit 2 for type b command
// - bits 1:0 give first command bit rate
// - field event 0x04, sdd done 0x08
// - rx done 0x40 after sdd; host checks
// - collision threshold from low field bits
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ntid_map.vh"
module ntid_regs (
  input  wire        clk,
  input  wire        rst,
  input  wire        vin_por,
  input  wire        enable_n_rst,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        read_burst_done,
  input  wire        above_wake_level,
  input  wire        above_collision_level,
  input  wire        first_cmd_valid,
  input  wire        type_f_coding,
  input  wire        passive_106,
  input  wire        type_b_emulation,
  input  wire [1:0]  first_cmd_rate,
  input  wire        field_detected,
  input  wire        sdd_completed,
  input  wire        rx_completed,
  output wire [2:0]  wake_level,
  output wire        wake_detect_on,
  output wire [2:0]  collision_level,
  output wire        extended_rf_range,
  output wire        sdd_enable,
  output wire [3:0]  id_length,
  output wire [79:0] target_id,
  output reg  [7:0]  ce_event_code
);
  // detection level lives on the input supply, so only vin_por clears it
  reg  [7:0]  det_q;
  reg  [7:0]  low_q;
  reg  [7:0]  id_q [0:9];
  reg  [3:0]  id_wptr_q;
  reg  [4:0]  proto_q;
  reg         aw_hold_q;
  reg  [11:0] aw_addr_q;
  reg         w_hold_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  wire        wr_fire;
  wire        rd_fire;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  wire        wr_lane0;
  wire        wr_ok;
  reg  [31:0] rd_d;
  reg         rd_ok;
  integer     k;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  assign wr_lane0 = w_hold_q ? w_strb_q[0] : s_axi_wstrb[0];
  assign wr_fire = (aw_hold_q || s_axi_awvalid) &&
                   (w_hold_q || s_axi_wvalid) && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  assign wake_level        = det_q[2:0];
  assign wake_detect_on    = |det_q[2:0];
  assign extended_rf_range = det_q[`NTID_BIT_EXT_RANGE];
  assign sdd_enable        = det_q[`NTID_BIT_SDD_EN];
  assign collision_level   = low_q[2:0];
  // code 11 is illegal; treated as 4 bytes to keep the engine bounded
  assign id_length = (det_q[7:6] == `NTID_SZ_7)  ? `NTID_LEN_7 :
                     (det_q[7:6] == `NTID_SZ_10) ? `NTID_LEN_10 :
                     `NTID_LEN_4;

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_id
      assign target_id[g*8 +: 8] = id_q[g];
    end
  endgenerate

  assign wr_ok = (wr_addr == `NTID_ADDR_LOW_FIELD) ||
                 (wr_addr == `NTID_ADDR_TARGET_ID) ||
                 (wr_addr == `NTID_ADDR_DETECT_LVL) ||
                 (wr_addr == `NTID_ADDR_PROTO_STAT) ||
                 (wr_addr == `NTID_ADDR_CE_EVENT) ||
                 (wr_addr[11:2] >= `NTID_ADDR_ID_BYTE0 >> 2 &&
                  wr_addr[11:2] < (`NTID_ADDR_ID_BYTE0 >> 2) + 10'd10);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= 12'h000;
      w_hold_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NTID_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `NTID_RESP_OKAY : `NTID_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // supply domain register: enable-low does not touch it
  always @(posedge clk or posedge vin_por) begin
    if (vin_por) begin
      det_q <= `NTID_DET_RESET;
    end else if (wr_fire && wr_lane0 &&
                 wr_addr == `NTID_ADDR_DETECT_LVL) begin
      det_q <= wr_data[7:0] & `NTID_DET_WMASK;
    end
  end

  // id bytes: a write to the id port steps a pointer, like a burst
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q     <= 8'h00;
      id_wptr_q <= 4'h0;
      for (k = 0; k < 10; k = k + 1)
        id_q[k] <= 8'h00;
    end else if (wr_fire && wr_lane0) begin
      if (wr_addr == `NTID_ADDR_LOW_FIELD)
        low_q <= wr_data[7:0];
      if (wr_addr == `NTID_ADDR_DETECT_LVL)
        id_wptr_q <= 4'h0;
      if (wr_addr == `NTID_ADDR_TARGET_ID) begin
        id_q[id_wptr_q] <= wr_data[7:0];
        id_wptr_q <= (id_wptr_q + 4'h1 >= id_length) ? 4'h0 :
                     id_wptr_q + 4'h1;
      end
      if (wr_addr[11:2] >= `NTID_ADDR_ID_BYTE0 >> 2 &&
          wr_addr[11:2] < (`NTID_ADDR_ID_BYTE0 >> 2) + 10'd10)
        id_q[wr_addr[5:2]] <= wr_data[7:0];
    end
  end

  // protocol capture; a new first command wins over the read clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      proto_q <= `NTID_PROTO_RESET;
    end else if (!enable_n_rst) begin
      proto_q <= `NTID_PROTO_RESET;
    end else if (first_cmd_valid) begin
      proto_q <= {type_f_coding, passive_106, type_b_emulation,
                  first_cmd_rate};
    end else if (read_burst_done) begin
      proto_q <= `NTID_PROTO_RESET;
    end
  end
  // bits 1:0 pass the rate code as decoded, 00 after reset or read clear
  // bit 3 and bit 2 come from the decoder strobes

  // last card-emulation event code; sdd done only when sdd is enabled
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ce_event_code <= 8'h00;
    end else if (rx_completed) begin
      ce_event_code <= `NTID_IRQ_RX_DONE;
    end else if (sdd_completed && sdd_enable) begin
      ce_event_code <= `NTID_IRQ_SDD_DONE;
    end else if (field_detected) begin
      ce_event_code <= `NTID_IRQ_FIELD;
    end
  end

  always @* begin
    rd_d  = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `NTID_ADDR_LOW_FIELD:  rd_d[7:0] = low_q;
      `NTID_ADDR_TARGET_ID:  rd_d[7:0] = id_q[0];
      `NTID_ADDR_DETECT_LVL: rd_d[7:0] = det_q;
      `NTID_ADDR_PROTO_STAT: rd_d[7:0] = {above_wake_level,
                                         above_collision_level, 1'b0,
                                         proto_q};
      `NTID_ADDR_CE_EVENT:   rd_d[7:0] = ce_event_code;
      default: begin
        if (s_axi_araddr[11:2] >= `NTID_ADDR_ID_BYTE0 >> 2 &&
            s_axi_araddr[11:2] < (`NTID_ADDR_ID_BYTE0 >> 2) + 10'd10)
          rd_d[7:0] = id_q[s_axi_araddr[5:2]];
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `NTID_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? `NTID_RESP_OKAY : `NTID_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [shared/ntid_map.vh]
// register map, field positions and reset values of the target id/detect bank
// assumes inclusion by bare name from design and bench files
`ifndef NTID_MAP_VH
`define NTID_MAP_VH
`define NTID_IDX_LOW_FIELD    8'h16
`define NTID_IDX_TARGET_ID    8'h17
`define NTID_IDX_DETECT_LVL   8'h18
`define NTID_IDX_PROTO_STAT   8'h19
`define NTID_ADDR_LOW_FIELD   12'h058
`define NTID_ADDR_TARGET_ID   12'h05C
`define NTID_ADDR_DETECT_LVL  12'h060
`define NTID_ADDR_PROTO_STAT  12'h064
`define NTID_ADDR_CE_EVENT    12'h068
`define NTID_ADDR_ID_BYTE0    12'h080
`define NTID_ID_MAX_BYTES     4'hA
`define NTID_DET_RESET        8'h00
`define NTID_PROTO_RESET      5'h00
`define NTID_DET_WMASK        8'hEF
`define NTID_BIT_SDD_EN       5
`define NTID_BIT_EXT_RANGE    3
`define NTID_SZ_4             2'h0
`define NTID_SZ_7             2'h1
`define NTID_SZ_10            2'h2
`define NTID_LEN_4            4'h4
`define NTID_LEN_7            4'h7
`define NTID_LEN_10           4'hA
`define NTID_IRQ_FIELD        8'h04
`define NTID_IRQ_SDD_DONE     8'h08
`define NTID_IRQ_RX_DONE      8'h40
`define NTID_RESP_OKAY        2'h0
`define NTID_RESP_SLVERR      2'h2
`endif

// [sim/ntid_host.sv]
// host model: axi4-lite master whose tasks the bench calls
// assumes the slave shares clk; bready and rready stay high
`timescale 1ns/1ps
module ntid_host (
  input  wire        clk,
  output reg  [11:0] s_axi_awaddr = 12'h000,
  output reg         s_axi_awvalid = 1'b0,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata = 32'h00000000,
  output reg         s_axi_wvalid = 1'b0,
  input  wire        s_axi_wready,
  input  wire        s_axi_bvalid,
  output wire        s_axi_bready,
  output reg  [11:0] s_axi_araddr = 12'h000,
  output reg         s_axi_arvalid = 1'b0,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output wire        s_axi_rready
);
  assign s_axi_bready = 1'b1;
  assign s_axi_rready = 1'b1;
  // readies are sampled at the rising edge itself, before the slave's
  // registers update, so each channel drops exactly when it is taken
  task automatic wr(input [11:0] a, input [31:0] v);
    logic pa, pw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    {pa, pw} = 2'b11;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
      @(posedge clk);
    while (!s_axi_bvalid);
  endtask
  task automatic rd(input [11:0] a, output [31:0] v, output [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge clk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge clk);
    while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// [sim/ntid_regs_sva.sv]
// checker for the target id/detect bank, bound onto ntid_regs
// assumes one clock and the active-high async rst
`timescale 1ns/1ps
`include "ntid_map.vh"
module ntid_regs_sva (
  input wire        clk,
  input wire        rst,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire        above_wake_level,
  input wire        above_collision_level,
  input wire        field_detected,
  input wire        sdd_completed,
  input wire        rx_completed,
  input wire [2:0]  wake_level,
  input wire        wake_detect_on,
  input wire [3:0]  id_length,
  input wire        sdd_enable,
  input wire [7:0]  ce_event_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_WAKE: assert property (wake_detect_on == (wake_level != 3'h0))
    else $error("wake detect enable wrong");
  AST_LEN: assert property (id_length inside {4'h4, 4'h7, 4'hA})
    else $error("id length not 4, 7 or 10");
  AST_EVF: assert property (field_detected && !sdd_completed &&
    !rx_completed |=> ce_event_code == `NTID_IRQ_FIELD) else $error("no 04");
  AST_EVS: assert property (sdd_completed && sdd_enable &&
    !rx_completed |=> ce_event_code == `NTID_IRQ_SDD_DONE)
    else $error("no 08");
  AST_EVNOSDD: assert property (sdd_completed && !sdd_enable &&
    !rx_completed && !field_detected |=> $stable(ce_event_code))
    else $error("sdd event while sdd off");
  AST_EVR: assert property (rx_completed |=> ce_event_code == 8'h40)
    else $error("no 40");
  AST_EVHOLD: assert property (!field_detected && !sdd_completed &&
    !rx_completed |=> $stable(ce_event_code)) else $error("event moved");
  AST_EVSET: assert property (ce_event_code inside {0, 4, 8, 64})
    else $error("bad event code");
  AST_LIVE: assert property ($rose(s_axi_rvalid) &&
    $past(s_axi_araddr) == `NTID_ADDR_PROTO_STAT |-> s_axi_rdata[7:5] ==
    {$past(above_wake_level), $past(above_collision_level), 1'b0})
    else $error("live bits wrong");
endmodule

// [sim/tb_nfc_target_id_and_detect_regs.sv]
// bench: host register traffic plus rf-side pulses into ntid_regs
// assumes ntid_host and ntid_regs_sva are compiled before it
`timescale 1ns/1ps
`include "ntid_map.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module tb_nfc_target_id_and_detect_regs;
  logic        clk = 0, rst = 1, vin_por = 1, enable_n_rst = 1;
  logic        above_wake_level = 0, above_collision_level = 0;
  logic [4:0]  pv = 0, cmd = 0;
  wire  [11:0] s_axi_awaddr, s_axi_araddr;
  wire  [31:0] s_axi_wdata, s_axi_rdata;
  wire  [1:0]  s_axi_rresp;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire         s_axi_rvalid, s_axi_rready, wake_detect_on, sdd_enable;
  wire         extended_rf_range;
  wire  [2:0]  wake_level;
  wire  [3:0]  id_length;
  wire  [79:0] target_id;
  wire  [7:0]  ce_event_code;
  int          fails = 0, samples_checked = 0, i, j, n;
  logic [31:0] d;
  logic [1:0]  r;
  logic [4:0]  tbl [3] = '{5'h09, 5'h05, 5'h12};
  logic [7:0]  evc [3] = '{8'h04, 8'h08, 8'h40};
  always #2 clk = ~clk;
  ntid_host h (.*);
  ntid_regs dut (.*, .s_axi_wstrb(4'hF), .s_axi_bresp(),
    .collision_level(), .field_detected(pv[0]), .sdd_completed(pv[1]),
    .rx_completed(pv[2]), .first_cmd_valid(pv[3]),
    .read_burst_done(pv[4]), .type_f_coding(cmd[4]),
    .passive_106(cmd[3]), .type_b_emulation(cmd[2]),
    .first_cmd_rate(cmd[1:0]));
  task automatic rc(input [11:0] a, input [7:0] e);
    h.rd(a, d, r);
    `CHK(r, `NTID_RESP_OKAY)
    `CHK(d, {24'h000000, e})
  endtask
  task automatic pulse(input int b);
    @(posedge clk) pv[b] <= 1'b1;
    @(posedge clk) pv[b] <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clk);
    {rst, vin_por} <= 2'b00;
    rc(`NTID_ADDR_DETECT_LVL, `NTID_DET_RESET);
    rc(`NTID_ADDR_PROTO_STAT, 8'h00);
    for (i = 0; i < 3; i++) begin
      n = i == 0 ? 4 : i == 1 ? 7 : 10;
      h.wr(`NTID_ADDR_DETECT_LVL, {24'h0, i[1:0], 6'h3D});
      rc(`NTID_ADDR_DETECT_LVL, {i[1:0], 6'h2D});
      `CHK({sdd_enable, extended_rf_range, wake_level}, 5'h1D)
      `CHK(id_length, n[3:0])
      for (j = 0; j <= n; j++) h.wr(`NTID_ADDR_TARGET_ID, 32'h30 + j);
      for (j = 1; j < n; j++) rc(`NTID_ADDR_ID_BYTE0 + 12'(4 * j), 8'(48 + j));
      `CHK(target_id[7:0], 8'(48 + n))
    end
    h.wr(`NTID_ADDR_DETECT_LVL, 32'h08);
    `CHK({wake_detect_on, extended_rf_range}, 2'b01)
    h.wr(`NTID_ADDR_DETECT_LVL, 32'h2D);
    @(posedge clk) {rst, enable_n_rst} <= 2'b10;
    @(posedge clk) {rst, enable_n_rst} <= 2'b01;
    rc(`NTID_ADDR_DETECT_LVL, 8'h2D);
    @(posedge clk) vin_por <= 1'b1;
    @(posedge clk) vin_por <= 1'b0;
    rc(`NTID_ADDR_DETECT_LVL, 8'h00);
    @(posedge clk) {above_wake_level, above_collision_level} <= 2'b11;
    for (i = 0; i < 3; i++) begin
      cmd <= tbl[i];
      pulse(3);
      rc(`NTID_ADDR_PROTO_STAT, {3'b110, tbl[i]});
      pulse(4);
      rc(`NTID_ADDR_PROTO_STAT, 8'hC0);
    end
    pulse(3);
    @(posedge clk) enable_n_rst <= 1'b0;
    @(posedge clk) enable_n_rst <= 1'b1;
    rc(`NTID_ADDR_PROTO_STAT, 8'hC0);
    @(posedge clk) above_collision_level <= 1'b0;
    h.wr(`NTID_ADDR_PROTO_STAT, 32'h3F);
    rc(`NTID_ADDR_PROTO_STAT, 8'h80);
    h.rd(12'hFF0, d, r);
    `CHK(r, `NTID_RESP_SLVERR)
    pulse(0);
    rc(`NTID_ADDR_CE_EVENT, evc[0]);
    pulse(1);
    rc(`NTID_ADDR_CE_EVENT, evc[0]);
    h.wr(`NTID_ADDR_DETECT_LVL, 32'h20);
    for (i = 1; i < 3; i++) begin
      pulse(i);
      rc(`NTID_ADDR_CE_EVENT, evc[i]);
    end
    end_sim;
  end
endmodule
bind ntid_regs ntid_regs_sva chk (.*);
